/* File: pkg/aste_pkg.sv */
// constants and types of the analog-input sample timing engine block
// Operation
// - three independent analog-input timing engines
// - primary engine plus secondary zero and one
// - one engine sequences channels of many modules
// - refuse module claimed by two tasks
// - triggers from software, digital edge, analog compare
// - start, reference, pause from analog or digital
// - digital triggers from at most two modules
// - each sample clock pulse starts one sample
// - sample clock internal or external selectable
// - sample clock routable, active high by default
// - internal sample clock divides the timebase
// - timebase selectable, never driven to outputs
// - filters on engine 0 ext clock and digital triggers, not timebase
// - enabled filter samples input each filter tick
package aste_pkg;
    localparam int NUM_ENG = 3;
    localparam int NUM_MOD = 8;
    localparam int NUM_TERM = 2;
    localparam int NUM_DIG = 2;
    localparam int FILT_LEN = 4;
    // engine indices
    localparam int ENG_PRIMARY = 0;
    localparam int ENG_SEC_ZERO = 1;
    localparam int ENG_SEC_ONE = 2;
    // register word offsets (byte addresses); engine block stride
    localparam logic [7:0] ENG_STRIDE = 8'h10;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_DIV = 4'h4;
    localparam logic [3:0] OFS_MODS = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;
    localparam logic [7:0] OFS_ROUTE = 8'h30;
    localparam logic [7:0] OFS_FILT = 8'h34;
    localparam logic [7:0] OFS_ERR = 8'h38;
    localparam logic [7:0] OFS_ID = 8'h3C;
    // identity value, arbitrary
    localparam logic [31:0] ID_VALUE = 32'h5A5A_0003;
    // control field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CLK_EXT = 1;
    localparam int CTRL_TB_EXT = 2;
    localparam int CTRL_SW_START = 3;
    localparam int CTRL_SW_REF = 4;
    localparam int CTRL_SW_PAUSE = 5;
    localparam int CTRL_ST_LSB = 8;
    localparam int CTRL_RF_LSB = 11;
    localparam int CTRL_PS_LSB = 14;
    localparam int CTRL_ST_EDGE = 17;
    localparam int CTRL_RF_EDGE = 18;
    localparam int CTRL_PS_LVL = 19;
    localparam int CTRL_CLK_SRC_LSB = 20;
    // trigger source selection codes (3 bits)
    localparam logic [2:0] SRC_SOFT = 3'h0;
    localparam logic [2:0] SRC_TERM0 = 3'h1;
    localparam logic [2:0] SRC_TERM1 = 3'h2;
    localparam logic [2:0] SRC_DIG0 = 3'h3;
    localparam logic [2:0] SRC_DIG1 = 3'h4;
    localparam logic [2:0] SRC_ANALOG = 3'h5;
    // route register: per terminal 4 bits: enable, engine(2), invert
    localparam int ROUTE_W = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DIV_RESET = 32'h0000_0002;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        ASTE_IDLE = 2'b00,
        ASTE_ARMED = 2'b01,
        ASTE_RUN = 2'b11,
        ASTE_DONE = 2'b10
    } aste_state_e;
endpackage : aste_pkg

/* File: rtl/aste_engine_top.sv */
// three analog-input sample timing engines with a wishbone register file
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module aste_engine_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timebase_ext_i,
    input wire logic timebase_int_i,
    input wire logic filter_tick_i,
    input wire logic [1:0] programmable_function_terminal_i,
    input wire logic [1:0] dig_trig_i,
    input wire logic [2:0] analog_cmp_i,
    input wire logic [2:0] ext_sample_clk_i,
    output logic [1:0] programmable_function_terminal_o,
    output logic [1:0] programmable_function_terminal_oe_o,
    output logic [2:0] sample_clk_o,
    output logic [2:0] running_o,
    output logic [2:0] paused_o,
    output logic [2:0] ref_seen_o
);
    localparam int NE = aste_pkg::NUM_ENG;
    localparam int NM = aste_pkg::NUM_MOD;

    // synchronise every outside input except the internal timebase with two flops before use
    // packed as ext clocks, comparators, digital, terminals, timebase, tick
    logic [11:0] async_in;
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    assign async_in = {ext_sample_clk_i, analog_cmp_i, dig_trig_i,
                       programmable_function_terminal_i,
                       timebase_ext_i, filter_tick_i};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 12'h000;
            sync2_reg <= 12'h000;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end
    logic filt_tick_s;
    logic tb_ext_s;
    logic [1:0] term_s;
    logic [1:0] dig_s;
    logic [2:0] acmp_s;
    logic [2:0] xclk_s;
    assign filt_tick_s = sync2_reg[0];
    assign tb_ext_s = sync2_reg[1];
    assign term_s = sync2_reg[3:2];
    assign dig_s = sync2_reg[5:4];        // at most two digital modules
    assign acmp_s = sync2_reg[8:6];
    assign xclk_s = sync2_reg[11:9];

    // filter clock edge detect on the synchronised copy
    logic filt_tick_d_reg;
    logic filt_edge;
    always_ff @(posedge clk_i) begin
        if (rst_i) filt_tick_d_reg <= 1'b0;
        else filt_tick_d_reg <= filt_tick_s;
    end
    assign filt_edge = filt_tick_s & ~filt_tick_d_reg;

    // registers
    logic [31:0] ctrl_reg [NE];
    logic [31:0] div_reg [NE];
    logic [NM-1:0] mods_reg [NE];
    logic [31:0] route_reg;
    logic [4:0] filt_en_reg;
    logic [NE-1:0] err_reg;

    // debouncing filters on terminals, digital triggers and engine 0 ext clock
    // the timebase input has no filter by design
    // a pulse shorter than four filter ticks never fills the history
    logic [4:0] filt_in;
    logic [4:0] filt_out;
    assign filt_in = {xclk_s[0], dig_s, term_s};
    genvar gf;
    generate
        for (gf = 0; gf < 5; gf++) begin : g_filt
            logic [aste_pkg::FILT_LEN-1:0] hist_reg;
            logic stable_reg;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    hist_reg <= '0;
                    stable_reg <= 1'b0;
                end else if (filt_edge) begin
                    // one sample per filter clock rising edge
                    hist_reg <= {hist_reg[aste_pkg::FILT_LEN-2:0],
                                 filt_in[gf]};
                    if (&hist_reg) stable_reg <= 1'b1;
                    else if (~|hist_reg) stable_reg <= 1'b0;
                end
            end
            assign filt_out[gf] = filt_en_reg[gf] ? stable_reg : filt_in[gf];
        end
    endgenerate
    logic [1:0] term_f;
    logic [1:0] dig_f;
    assign term_f = filt_out[1:0];
    assign dig_f = filt_out[3:2];

    // bus decode
    // a write lands on the edge that takes the request; ack follows it
    logic bus_req;
    logic bus_wr;
    logic [1:0] eng_sel;
    logic [3:0] eng_ofs;
    logic in_eng;
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr = bus_req & wb_we_i;
    assign eng_sel = wb_adr_i[5:4];
    assign eng_ofs = wb_adr_i[3:0];
    assign in_eng = (wb_adr_i[7:6] == 2'b00) && (eng_sel != 2'b11);

    // a module already claimed by another engine is refused
    logic [NM-1:0] claimed_other [NE];
    logic [NE-1:0] mods_conflict;
    always_comb begin
        for (int e = 0; e < NE; e++) begin
            claimed_other[e] = '0;
            for (int o = 0; o < NE; o++)
                if (o != e) claimed_other[e] |= mods_reg[o];
            mods_conflict[e] = |(wb_dat_i[NM-1:0] & claimed_other[e]);
        end
    end

    // per engine logic: one engine instance each, independent
    logic [NE-1:0] sclk_pulse;
    genvar ge;
    generate
        for (ge = 0; ge < NE; ge++) begin : g_eng
            logic wr_here;
            assign wr_here = bus_wr && in_eng && eng_sel == 2'(ge);
            logic [31:0] c;
            assign c = ctrl_reg[ge];

            // register writes; software trigger bits self clear
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ctrl_reg[ge] <= aste_pkg::CTRL_RESET;
                    div_reg[ge] <= aste_pkg::DIV_RESET;
                    mods_reg[ge] <= '0;
                    err_reg[ge] <= 1'b0;
                end else begin
                    ctrl_reg[ge][aste_pkg::CTRL_SW_START +: 3] <= 3'b000;
                    if (wr_here && eng_ofs == aste_pkg::OFS_CTRL)
                        ctrl_reg[ge] <= wb_dat_i;
                    if (wr_here && eng_ofs == aste_pkg::OFS_DIV)
                        div_reg[ge] <= wb_dat_i;
                    if (wr_here && eng_ofs == aste_pkg::OFS_MODS) begin
                        if (mods_conflict[ge]) err_reg[ge] <= 1'b1;
                        else mods_reg[ge] <= wb_dat_i[NM-1:0];
                    end
                    // one request per bus cycle: a claim error and a clear
                    if (bus_wr && wb_adr_i == aste_pkg::OFS_ERR &&
                        wb_dat_i[ge] && !(wr_here && mods_conflict[ge]))
                        err_reg[ge] <= 1'b0;
                end
            end

            // trigger source select: software, digital, analog
            function automatic logic pick(input logic [2:0] s,
                                          input logic sw);
                case (s)
                    aste_pkg::SRC_SOFT: pick = sw;
                    aste_pkg::SRC_TERM0: pick = term_f[0];
                    aste_pkg::SRC_TERM1: pick = term_f[1];
                    aste_pkg::SRC_DIG0: pick = dig_f[0];
                    aste_pkg::SRC_DIG1: pick = dig_f[1];
                    aste_pkg::SRC_ANALOG: pick = acmp_s[ge];
                    default: pick = 1'b0;
                endcase
            endfunction
            logic st_raw;
            logic rf_raw;
            logic ps_raw;
            assign st_raw = pick(c[aste_pkg::CTRL_ST_LSB +: 3],
                                 c[aste_pkg::CTRL_SW_START])
                            ^ c[aste_pkg::CTRL_ST_EDGE];
            assign rf_raw = pick(c[aste_pkg::CTRL_RF_LSB +: 3],
                                 c[aste_pkg::CTRL_SW_REF])
                            ^ c[aste_pkg::CTRL_RF_EDGE];
            assign ps_raw = pick(c[aste_pkg::CTRL_PS_LSB +: 3],
                                 c[aste_pkg::CTRL_SW_PAUSE])
                            ^ c[aste_pkg::CTRL_PS_LVL];
            logic st_d_reg;
            logic rf_d_reg;
            logic st_edge;
            logic rf_edge;
            assign st_edge = st_raw & ~st_d_reg;
            assign rf_edge = rf_raw & ~rf_d_reg;

            // timebase: internal or external, kept on-chip
            logic tb;
            logic tb_d_reg;
            logic tb_edge;
            assign tb = c[aste_pkg::CTRL_TB_EXT] ? tb_ext_s : timebase_int_i;
            assign tb_edge = tb & ~tb_d_reg;

            // external sample clock source: filtered pin for engine 0, raw pin for the others
            logic xsrc;
            logic xsrc_d_reg;
            assign xsrc = (ge == 0) ? filt_out[4] : xclk_s[ge];

            aste_pkg::aste_state_e st_reg;
            logic [31:0] cnt_reg;
            logic div_hit;
            logic int_pulse;
            logic ext_pulse;
            // a divisor of zero or one pulses on every timebase edge
            assign div_hit = (cnt_reg + 32'h0000_0001 >= div_reg[ge]);
            assign int_pulse = tb_edge && div_hit;
            assign ext_pulse = xsrc & ~xsrc_d_reg;
            // pulse stops while paused; each pulse starts one sample
            assign sclk_pulse[ge] = (st_reg == aste_pkg::ASTE_RUN) &&
                                    !ps_raw &&
                                    (c[aste_pkg::CTRL_CLK_EXT] ?
                                     ext_pulse : int_pulse);

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    st_d_reg <= 1'b0;
                    rf_d_reg <= 1'b0;
                    tb_d_reg <= 1'b0;
                    xsrc_d_reg <= 1'b0;
                    cnt_reg <= 32'h0000_0000;
                    st_reg <= aste_pkg::ASTE_IDLE;
                end else begin
                    st_d_reg <= st_raw;
                    rf_d_reg <= rf_raw;
                    tb_d_reg <= tb;
                    xsrc_d_reg <= xsrc;
                    // divisor counter advances per timebase edge
                    if (st_reg != aste_pkg::ASTE_RUN)
                        cnt_reg <= 32'h0000_0000;
                    else if (tb_edge && !ps_raw)
                        cnt_reg <= div_hit ? 32'h0000_0000
                                           : cnt_reg + 32'h0000_0001;
                    case (st_reg)
                        aste_pkg::ASTE_IDLE:
                            if (c[aste_pkg::CTRL_RUN])
                                st_reg <= aste_pkg::ASTE_ARMED;
                        aste_pkg::ASTE_ARMED:
                            if (!c[aste_pkg::CTRL_RUN])
                                st_reg <= aste_pkg::ASTE_IDLE;
                            else if (st_edge)
                                st_reg <= aste_pkg::ASTE_RUN;
                        aste_pkg::ASTE_RUN:
                            if (!c[aste_pkg::CTRL_RUN])
                                st_reg <= aste_pkg::ASTE_IDLE;
                            else if (rf_edge)
                                st_reg <= aste_pkg::ASTE_DONE;
                        aste_pkg::ASTE_DONE:
                            if (!c[aste_pkg::CTRL_RUN])
                                st_reg <= aste_pkg::ASTE_IDLE;
                        default: st_reg <= aste_pkg::ASTE_IDLE;
                    endcase
                end
            end

            // status outputs from flops
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sample_clk_o[ge] <= 1'b0;
                    running_o[ge] <= 1'b0;
                    paused_o[ge] <= 1'b0;
                    ref_seen_o[ge] <= 1'b0;
                end else begin
                    sample_clk_o[ge] <= sclk_pulse[ge]; // one cycle
                    running_o[ge] <= st_reg == aste_pkg::ASTE_RUN;
                    paused_o[ge] <= st_reg == aste_pkg::ASTE_RUN && ps_raw;
                    ref_seen_o[ge] <= st_reg == aste_pkg::ASTE_DONE;
                end
            end
        end
    endgenerate

    // terminal routing: [0]=enable [2:1]=engine [3]=invert
    // only sample clocks are routable, the timebase never is
    logic [1:0] term_q_reg;
    genvar gt;
    generate
        for (gt = 0; gt < aste_pkg::NUM_TERM; gt++) begin : g_term
            logic [3:0] r;
            logic p;
            assign r = route_reg[gt*aste_pkg::ROUTE_W +: aste_pkg::ROUTE_W];
            assign p = (r[2:1] == 2'b11) ? 1'b0 : sclk_pulse[r[2:1]];
            always_ff @(posedge clk_i) begin
                if (rst_i) term_q_reg[gt] <= 1'b0;
                else term_q_reg[gt] <= p ^ r[3]; // active high default
            end
            assign programmable_function_terminal_o[gt] = term_q_reg[gt];
            assign programmable_function_terminal_oe_o[gt] = r[0];
        end
    endgenerate

    // shared registers and bus answer, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_reg <= aste_pkg::ROUTE_RESET;
            filt_en_reg <= 5'h00;
        end else begin
            if (bus_wr && wb_adr_i == aste_pkg::OFS_ROUTE)
                route_reg <= wb_dat_i;
            if (bus_wr && wb_adr_i == aste_pkg::OFS_FILT)
                filt_en_reg <= wb_dat_i[4:0];
        end
    end

    logic [31:0] rd_mux;
    logic [1:0] es;
    assign es = (eng_sel == 2'b11) ? 2'b00 : eng_sel;
    assign rd_mux =
        !in_eng ? (wb_adr_i == aste_pkg::OFS_ROUTE ? route_reg :
                   wb_adr_i == aste_pkg::OFS_FILT ? {27'h0, filt_en_reg} :
                   wb_adr_i == aste_pkg::OFS_ERR ? {29'h0, err_reg} :
                   wb_adr_i == aste_pkg::OFS_ID ? aste_pkg::ID_VALUE :
                   32'h0000_0000) :
        eng_ofs == aste_pkg::OFS_CTRL ? ctrl_reg[es] :
        eng_ofs == aste_pkg::OFS_DIV ? div_reg[es] :
        eng_ofs == aste_pkg::OFS_MODS ? {24'h0, mods_reg[es]} :
        eng_ofs == aste_pkg::OFS_STAT ?
            {28'h0, ref_seen_o[es], paused_o[es], running_o[es],
             err_reg[es]} : 32'h0000_0000;

    // ack is registered: one wait state, and it drops after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_mux;
        end
    end
endmodule : aste_engine_top

/* File: testbench/aste_chk.sv */
// assertion checker bound to the sample timing engine top
`timescale 1ns/100ps
module aste_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input logic wb_ack_o,
    input logic [2:0] sample_clk_o,
    input logic [2:0] running_o,
    input logic [2:0] paused_o,
    input logic [2:0] ref_seen_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a taken request gets exactly one ack pulse, one cycle later
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack;
        s_req |=> s_answer;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer wrong");
    // reset silences every engine, whatever it was doing
    property p_quiet;
        disable iff (1'b0) rst_i |=> running_o == 3'h0 && sample_clk_o == 3'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("engine active after reset");
    property p_sclk0;
        sample_clk_o[0] |=> !sample_clk_o[0];
    endproperty
    a_sclk0: assert property (p_sclk0)
        else $error("engine 0 sample pulse too wide");
    property p_sclk1;
        sample_clk_o[1] |=> !sample_clk_o[1];
    endproperty
    a_sclk1: assert property (p_sclk1)
        else $error("engine 1 sample pulse too wide");
    property p_sclk2;
        sample_clk_o[2] |=> !sample_clk_o[2];
    endproperty
    a_sclk2: assert property (p_sclk2)
        else $error("engine 2 sample pulse too wide");
    // pulse and running are registered from the same state, so no pulse comes once running falls
    property p_run;
        sample_clk_o[0] |-> running_o[0] || $past(running_o[0]);
    endproperty
    a_run: assert property (p_run)
        else $error("sample pulse while not running");
    property p_pause;
        paused_o[0] [*3] |-> !sample_clk_o[0];
    endproperty
    a_pause: assert property (p_pause)
        else $error("sample pulse while paused");
    property p_ref;
        $rose(ref_seen_o[0]) |-> ##[0:2] !running_o[0];
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference did not stop engine");
endmodule : aste_chk
bind aste_engine_top aste_chk u_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .sample_clk_o, .running_o, .paused_o, .ref_seen_o
);

/* File: testbench/aste_far_model.sv */
// far side: timebases, filter clock, trigger lines, external clocks
`timescale 1ns/100ps
module aste_far_model (
    input wire logic clk_i,
    output logic timebase_int_o,
    output logic timebase_ext_o,
    output logic filter_tick_o,
    output logic [6:0] trig_o,
    output logic [2:0] ext_clk_o
);
    logic [2:0] ext_en = 3'h0;
    logic [3:0] tick = 4'h0;
    initial begin
        timebase_int_o = 1'b0;
        timebase_ext_o = 1'b0;
        filter_tick_o = 1'b0;
        trig_o = 7'h00;
        ext_clk_o = 3'h0;
    end
    // internal timebase: one rising edge every two cycles
    always @(posedge clk_i) begin
        timebase_int_o <= ~timebase_int_o;
        filter_tick_o <= ~filter_tick_o;
        tick <= tick + 4'h1;
        timebase_ext_o <= tick[1];
        // two-cycle wide so the synchronisers never miss it
        ext_clk_o <= ext_en & {3{tick[3:1] == 3'h0}};
    end
    // lines: terminals 1:0, digital modules 3:2, comparators 6:4
    task drive(input int idx, input logic v);
        trig_o[idx] <= v;
    endtask : drive
    task ext_run(input int e, input logic v);
        ext_en[e] <= v;
    endtask : ext_run
endmodule : aste_far_model

/* File: testbench/testbench.sv */
// self-checking bench for the sample timing engine block
`timescale 1ns/100ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, timebase_ext_i, timebase_int_i, filter_tick_i;
    logic [6:0] trig;
    logic [2:0] ext_sample_clk_i, sample_clk_o, running_o, paused_o;
    logic [2:0] ref_seen_o;
    logic [1:0] programmable_function_terminal_o;
    logic [1:0] programmable_function_terminal_oe_o;
    int err_total = 0, n_checks = 0, g, k, hi, bad;
    always #5 clk_i = ~clk_i;
    aste_engine_top dut (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .timebase_ext_i,
        .timebase_int_i, .filter_tick_i,
        .programmable_function_terminal_i(trig[1:0]),
        .dig_trig_i(trig[3:2]), .analog_cmp_i(trig[6:4]),
        .ext_sample_clk_i, .programmable_function_terminal_o,
        .programmable_function_terminal_oe_o, .sample_clk_o, .running_o,
        .paused_o, .ref_seen_o
    );
    aste_far_model far (
        .clk_i, .timebase_int_o(timebase_int_i),
        .timebase_ext_o(timebase_ext_i), .filter_tick_o(filter_tick_i),
        .trig_o(trig), .ext_clk_o(ext_sample_clk_i)
    );
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one classic cycle, held until ack is sampled high
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k == 50) begin
            err_total++;
            give_verdict();
        end
    endtask : bus
    // kind 0 running, 1 paused, 2 reference seen
    task wait_on(input int kind, input int e);
        for (k = 0; k < 300; k++) begin
            @(posedge clk_i);
            if (kind == 0 && running_o[e] === 1'b1) break;
            if (kind == 1 && paused_o[e] === 1'b1) break;
            if (kind == 2 && ref_seen_o[e] === 1'b1) break;
        end
        if (k == 300) begin
            err_total++;
            give_verdict();
        end
    endtask : wait_on
    // cycles between two sample pulses; 300 means none came
    task gap(input int e);
        for (k = 0; k < 300 && sample_clk_o[e] !== 1'b1; k++) @(posedge clk_i);
        for (g = 1; g < 300; g++) begin
            @(posedge clk_i);
            if (sample_clk_o[e] === 1'b1) break;
        end
        if (k == 300 || g == 300) begin
            err_total++;
            give_verdict();
        end
    endtask : gap
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int e = 0; e < 3; e++) begin
            bus(0, 8'(e * 16 + 4), 0);
            chk("div reset", 32'h0000_0002, rd);
            bus(0, 8'(e * 16), 0);
            chk("ctrl reset", 32'h0000_0000, rd);
        end
        bus(0, 8'h3c, 0);
        chk("id", aste_pkg::ID_VALUE, rd);
        bus(1, 8'h40, 32'hffff_ffff);
        bus(0, 8'h40, 0);
        chk("unmapped", 32'h0000_0000, rd);
        $display("test map done");
        // second claim of module 1 must be dropped and flagged
        bus(1, 8'h08, 32'h0000_0003);
        bus(1, 8'h18, 32'h0000_0006);
        bus(0, 8'h08, 0);
        chk("mods e0", 32'h0000_0003, rd);
        bus(0, 8'h18, 0);
        chk("mods e1", 32'h0000_0000, rd);
        bus(0, 8'h38, 0);
        chk("err set", 1, |rd);
        bus(1, 8'h38, 32'hffff_ffff);
        bus(0, 8'h38, 0);
        chk("err clear", 0, rd);
        bus(1, 8'h18, 32'h0000_000c);
        bus(0, 8'h18, 0);
        chk("mods e1 ok", 32'h0000_000c, rd);
        $display("test modules done");
        // ref from digital 0, pause from own comparator, soft start
        for (int e = 0; e < 3; e++) begin
            bus(1, 8'(e * 16 + 4), 32'(3 + e));
            bus(1, 8'(e * 16), 32'h0001_5801);
            chk("armed", 0, running_o[e]);
            bus(1, 8'(e * 16), 32'h0001_5809);
            wait_on(0, e);
            gap(e);
            chk("period", 32'(6 + 2 * e), g);
        end
        far.drive(4, 1'b1);
        wait_on(1, 0);
        hi = 0;
        repeat (40) begin
            @(posedge clk_i);
            hi += sample_clk_o[0];
        end
        chk("paused pulses", 0, hi);
        far.drive(4, 1'b0);
        gap(0);
        chk("resumed", 6, g);
        chk("unpaused", 0, paused_o[0]);
        far.drive(2, 1'b1);
        repeat (10) @(posedge clk_i);
        far.drive(2, 1'b0);
        for (int e = 0; e < 3; e++) begin
            wait_on(2, e);
            repeat (2) @(posedge clk_i);
            chk("stopped", 0, running_o[e]);
            bus(0, 8'(e * 16 + 12), 0);
            chk("status", 32'h0000_0008, rd);
        end
        $display("test clock done");
        // every hardware start source on engine 2
        for (int s = 1; s < 6; s++) begin
            bus(1, 8'h20, 0);
            bus(1, 8'h20, 32'h0000_0001 | (32'(s) << 8));
            chk($sformatf("idle src %0d", s), 0, running_o[2]);
            far.drive(s == 5 ? 6 : s - 1, 1'b1);
            wait_on(0, 2);
            chk($sformatf("start src %0d", s), 1, running_o[2]);
            far.drive(s == 5 ? 6 : s - 1, 1'b0);
        end
        $display("test sources done");
        // terminal 0 plain, terminal 1 inverted, both from engine 2
        bus(1, 8'h30, 32'h0000_00d5);
        chk("oe", 3, programmable_function_terminal_oe_o);
        repeat (2) @(posedge clk_i);
        hi = 0;
        bad = 0;
        repeat (40) begin
            @(posedge clk_i);
            hi += programmable_function_terminal_o[0];
            bad += (programmable_function_terminal_o[1] !==
                ~programmable_function_terminal_o[0]);
        end
        chk("route pulses", 4, hi);
        chk("route invert", 0, bad);
        $display("test route done");
        bus(1, 8'h00, 0);
        bus(1, 8'h00, 32'h0000_0003);
        bus(1, 8'h00, 32'h0000_000b);
        far.ext_run(0, 1'b1);
        wait_on(0, 0);
        gap(0);
        chk("ext period", 16, g);
        bus(1, 8'h00, 0);
        bus(1, 8'h00, 32'h0000_0005);
        bus(1, 8'h00, 32'h0000_000d);
        wait_on(0, 0);
        gap(0);
        chk("ext timebase period", 12, g);
        $display("test external clock done");
        // a one-cycle glitch must not get through the filter
        bus(1, 8'h34, 32'h0000_0001);
        bus(1, 8'h10, 0);
        bus(1, 8'h10, 32'h0000_0101);
        far.drive(0, 1'b1);
        @(posedge clk_i);
        far.drive(0, 1'b0);
        repeat (40) @(posedge clk_i);
        chk("glitch", 0, running_o[1]);
        far.drive(0, 1'b1);
        wait_on(0, 1);
        chk("filtered start", 1, running_o[1]);
        $display("test filter done");
        give_verdict();
    end
endmodule : testbench
